// ---- logic/jld_params.svh ----
/*
  Constants of the jump and load decoder: opcodes, lengths, cycle budgets
  and reset values.
  Assumes it is included by bare name from the package and the decoder.
*/
`ifndef JLD_PARAMS_SVH
`define JLD_PARAMS_SVH

// opcode low nibbles that carry a field in the high nibble
`define JLD_NIB_JPCC   4'hd
`define JLD_NIB_JR     4'hb
`define JLD_NIB_LDIM   4'hc
`define JLD_NIB_LDRR   4'h8
`define JLD_NIB_LDRW   4'h9

// whole-byte opcodes
`define JLD_OP_JPIND   8'h30
`define JLD_OP_LDIRS   8'hc7
`define JLD_OP_LDIRD   8'hd7
`define JLD_OP_LDRR3   8'he4
`define JLD_OP_LDIR3   8'he5
`define JLD_OP_LDIM3   8'he6
`define JLD_OP_LDIMI   8'hd6
`define JLD_OP_LDRIR   8'hf5
`define JLD_OP_LDXS    8'h87
`define JLD_OP_LDXD    8'h97
`define JLD_OP_BIT     8'h47
`define JLD_OP_MIRL    8'hc3
`define JLD_OP_MIRS    8'hd3
`define JLD_OP_MXSL    8'he7
`define JLD_OP_MXSS    8'hf7
`define JLD_OP_MXLL    8'ha7
`define JLD_OP_MXLS    8'hb7

// instruction lengths in bytes
`define JLD_LEN_1      3'd1
`define JLD_LEN_2      3'd2
`define JLD_LEN_3      3'd3
`define JLD_LEN_4      3'd4

// cycle budgets
`define JLD_CYC_4      4'd4
`define JLD_CYC_6      4'd6
`define JLD_CYC_8      4'd8
`define JLD_CYC_10     4'd10
`define JLD_CYC_12     4'd12
`define JLD_CYC_14     4'd14
`define JLD_CYC_UNSUP  4'd4

// working register n sits at register address {prefix, n}
`define JLD_WREG_PFX   4'hc
// program counter after reset
`define JLD_PC_RESET   16'h0000

`endif

// ---- logic/jld_pkg.sv ----
/*
  Types of the jump and load decoder: states, instruction classes,
  operand kinds, decoded fields and the request bundles of its ports.
  Assumes jld_params.svh is on the include path.
*/
`include "jld_params.svh"

package jld_pkg;

  typedef enum logic [3:0] {
    JLD_FETCH, JLD_SPTR, JLD_SVAL, JLD_DPTR, JLD_JHI, JLD_JLO,
    JLD_BIT1, JLD_BIT2, JLD_MHI, JLD_MLO, JLD_MEM, JLD_PAD
  } jld_state_e_t;

  typedef enum logic [2:0] {
    JLD_C_JPCC, JLD_C_JPIND, JLD_C_JR, JLD_C_MOVE, JLD_C_BIT,
    JLD_C_MEM, JLD_C_BAD
  } jld_class_t;

  // immediate, register, register indirect, indexed
  typedef enum logic [1:0] {
    JLD_K_IMM, JLD_K_REG, JLD_K_IND, JLD_K_IDX
  } jld_kind_t;

  typedef struct packed {
    jld_class_t  cls;
    logic [2:0]  len;
    logic [3:0]  cyc;
    jld_kind_t   skind;
    jld_kind_t   dkind;
    logic [7:0]  saddr;
    logic [7:0]  daddr;
    logic [7:0]  imm;
    logic [7:0]  x;
    logic [15:0] xoff;
  } jld_dec_t;

  typedef struct packed {
    logic [7:0] raddr;
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } jld_reg_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        prog;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } jld_mem_req_t;

  typedef struct packed {
    jld_state_e_t    st;
    logic [15:0]     pc;
    logic [3:0]      cnt;
    logic [1:0]      idx;
    logic [3:0][7:0] ib;
    logic [7:0]      val;
    logic [7:0]      hi;
    logic            fetch_req;
    logic [3:0]      cond_code;
    jld_reg_req_t    reg_req;
    jld_mem_req_t    mem_req;
    logic            flags_we;
    logic            done;
    logic            unsup;
  } jld_state_t;

endpackage

// ---- logic/jld_decoder.sv ----
/*
  Decoder and sequencer for control transfer and data move instructions
  of an 8-bit core: jumps, relative jumps, register moves, bit loads and
  program or data memory moves.
  Assumes fetch, register file and memory all answer in the same cycle as
  the request flop is high (combinational read), writes land at the edge
  that ends the cycle in which the write strobe is high, and an outside
  evaluator turns cond_code into cond_ok in the same cycle as it changes.
*/
`timescale 1ns/10ps
`include "jld_params.svh"

module jld_decoder
  import jld_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  output logic              fetch_req,
  output logic [15:0]       fetch_addr,
  input  wire logic [7:0]   fetch_data,
  output logic [3:0]        cond_code,
  input  wire logic         cond_ok,
  output jld_reg_req_t      reg_req,
  input  wire logic [7:0]   reg_rdata,
  output jld_mem_req_t      mem_req,
  input  wire logic [7:0]   mem_rdata,
  output logic              flags_we,
  output logic              instr_done,
  output logic              unsup_op
);

  // working register number to register file address
  function automatic logic [7:0] wreg(input logic [3:0] n);
    return {`JLD_WREG_PFX, n};
  endfunction

  // sign extension of a byte to an address offset
  function automatic logic [15:0] sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // length, cycle budget and operand fields from the instruction bytes
  function automatic jld_dec_t decode(input logic [3:0][7:0] by);
    jld_dec_t d;
    d       = '0;
    d.cls   = JLD_C_MOVE;
    d.len   = `JLD_LEN_3;
    d.cyc   = `JLD_CYC_6;
    d.skind = JLD_K_REG;
    d.dkind = JLD_K_REG;
    d.x     = by[2];
    d.xoff  = 16'h0000;
    unique case (by[0])
      `JLD_OP_JPIND: begin
        d.cls = JLD_C_JPIND;
        d.len = `JLD_LEN_2;
        d.cyc = `JLD_CYC_8;
      end
      `JLD_OP_LDIRS: begin
        d.len   = `JLD_LEN_2;
        d.cyc   = `JLD_CYC_4;
        d.skind = JLD_K_IND;
        d.saddr = wreg(by[1][3:0]);
        d.daddr = wreg(by[1][7:4]);
      end
      `JLD_OP_LDIRD: begin
        d.len   = `JLD_LEN_2;
        d.cyc   = `JLD_CYC_4;
        d.dkind = JLD_K_IND;
        d.saddr = wreg(by[1][3:0]);
        d.daddr = wreg(by[1][7:4]);
      end
      `JLD_OP_LDRR3: begin
        d.saddr = by[1];
        d.daddr = by[2];
      end
      `JLD_OP_LDIR3: begin
        d.skind = JLD_K_IND;
        d.saddr = by[1];
        d.daddr = by[2];
      end
      `JLD_OP_LDIM3: begin
        d.skind = JLD_K_IMM;
        d.daddr = by[1];
        d.imm   = by[2];
      end
      `JLD_OP_LDIMI: begin
        d.skind = JLD_K_IMM;
        d.dkind = JLD_K_IND;
        d.daddr = by[1];
        d.imm   = by[2];
      end
      `JLD_OP_LDRIR: begin
        d.dkind = JLD_K_IND;
        d.saddr = by[1];
        d.daddr = by[2];
      end
      `JLD_OP_LDXS: begin
        d.skind = JLD_K_IDX;
        d.saddr = wreg(by[1][3:0]);
        d.daddr = wreg(by[1][7:4]);
      end
      `JLD_OP_LDXD: begin
        d.dkind = JLD_K_IDX;
        d.saddr = wreg(by[1][7:4]);
        d.daddr = wreg(by[1][3:0]);
      end
      `JLD_OP_BIT: d.cls = JLD_C_BIT;
      `JLD_OP_MIRL, `JLD_OP_MIRS: begin
        d.cls = JLD_C_MEM;
        d.len = `JLD_LEN_2;
        d.cyc = `JLD_CYC_10;
      end
      `JLD_OP_MXSL, `JLD_OP_MXSS: begin
        d.cls  = JLD_C_MEM;
        d.cyc  = `JLD_CYC_12;
        d.xoff = sext(by[2]);
      end
      `JLD_OP_MXLL, `JLD_OP_MXLS: begin
        d.cls  = JLD_C_MEM;
        d.len  = `JLD_LEN_4;
        d.cyc  = `JLD_CYC_14;
        d.xoff = {by[3], by[2]}; // low byte first
      end
      default: begin
        // nibble-coded forms: high nibble is condition or register
        unique case (by[0][3:0])
          `JLD_NIB_JPCC: d.cls = JLD_C_JPCC;
          `JLD_NIB_JR: begin
            d.cls = JLD_C_JR;
            d.len = `JLD_LEN_2;
          end
          `JLD_NIB_LDIM, `JLD_NIB_LDRR, `JLD_NIB_LDRW: begin
            d.len   = `JLD_LEN_2;
            d.cyc   = `JLD_CYC_4;
            d.skind = (by[0][3:0] == `JLD_NIB_LDIM) ? JLD_K_IMM : JLD_K_REG;
            d.imm   = by[1];
            d.saddr = (by[0][3:0] == `JLD_NIB_LDRW) ? wreg(by[0][7:4])
                                                     : by[1];
            d.daddr = (by[0][3:0] == `JLD_NIB_LDRW) ? by[1]
                                                     : wreg(by[0][7:4]);
          end
          default: begin
            // other instructions are not ours: skip one byte
            d.cls = JLD_C_BAD;
            d.len = `JLD_LEN_1;
            d.cyc = `JLD_CYC_UNSUP;
          end
        endcase
        if (by[0][3:0] == `JLD_NIB_JPCC) begin
          d.cyc = `JLD_CYC_8;
        end
      end
    endcase
    return d;
  endfunction

  // source value known: write a plain register or go fetch the pointer
  function automatic jld_state_t put_val(input jld_state_t s,
                                         input jld_dec_t   d,
                                         input logic [7:0] v);
    jld_state_t r;
    r     = s;
    r.val = v;
    if (d.dkind == JLD_K_REG) begin
      r.reg_req.we    = 1'b1;
      r.reg_req.waddr = d.daddr;
      r.reg_req.wdata = v;
      r.st            = JLD_PAD;
    end else begin
      r.reg_req.raddr = d.daddr;
      r.st            = JLD_DPTR;
    end
    return r;
  endfunction

  jld_state_t      c_r;
  jld_state_t      c_nxt;
  logic [3:0][7:0] by;
  jld_dec_t        d;
  logic            cap;
  logic            last;
  logic [3:0]      pair;
  logic            direct;

  // one cycle of the sequencer
  always_comb begin
    c_nxt = c_r;
    by    = c_r.ib;
    cap   = (c_r.st == JLD_FETCH) && c_r.fetch_req;
    if (cap) begin
      by[c_r.idx] = fetch_data;
    end
    d      = decode(by);
    last   = cap && (({1'b0, c_r.idx} + 3'd1) == d.len);
    pair   = by[1][3:0];
    direct = (pair[3:1] == 3'b000) && (d.len == `JLD_LEN_4);
    c_nxt.cnt          = c_r.cnt + 4'd1;
    c_nxt.reg_req.we   = 1'b0;
    c_nxt.mem_req.rd   = 1'b0;
    c_nxt.mem_req.wr   = 1'b0;
    c_nxt.flags_we     = 1'b0;
    c_nxt.done         = 1'b0;
    c_nxt.unsup        = 1'b0;
    unique case (c_r.st)
      JLD_FETCH: begin
        if (!c_r.fetch_req) begin
          c_nxt.fetch_req = 1'b1;
          c_nxt.cnt       = 4'd0;
        end else begin
          c_nxt.ib[c_r.idx] = fetch_data;
          c_nxt.pc          = c_r.pc + 16'h0001;
          c_nxt.idx         = c_r.idx + 2'd1;
          if (c_r.idx == 2'd0) begin
            c_nxt.cond_code = fetch_data[7:4];
          end
        end
        // last byte in hand: first step of execution in the same cycle
        if (last) begin
          c_nxt.fetch_req = 1'b0;
          c_nxt.idx       = 2'd0;
          unique case (d.cls)
            JLD_C_JPCC: begin
              if (cond_ok) begin
                c_nxt.pc = {by[1], by[2]};
              end
              c_nxt.st = JLD_PAD;
            end
            JLD_C_JR: begin
              // pc here addresses the offset byte, one more is the base
              if (cond_ok) begin
                c_nxt.pc = c_r.pc + 16'h0001 + sext(by[1]);
              end
              c_nxt.st = JLD_PAD;
            end
            JLD_C_JPIND: begin
              c_nxt.reg_req.raddr = {by[1][7:1], 1'b0};
              c_nxt.st            = JLD_JHI;
            end
            JLD_C_MOVE: begin
              if (d.skind == JLD_K_IMM) begin
                c_nxt = put_val(c_nxt, d, d.imm);
              end else begin
                c_nxt.reg_req.raddr = d.saddr;
                c_nxt.st = (d.skind == JLD_K_REG) ? JLD_SVAL : JLD_SPTR;
              end
            end
            JLD_C_BIT: begin
              c_nxt.reg_req.raddr = by[1][0] ? wreg(by[1][7:4]) : by[2];
              c_nxt.st            = JLD_BIT1;
            end
            JLD_C_MEM: begin
              c_nxt.reg_req.raddr = wreg({pair[3:1], 1'b0});
              c_nxt.st            = JLD_MHI;
            end
            default: begin
              c_nxt.unsup = 1'b1;
              c_nxt.st    = JLD_PAD;
            end
          endcase
        end
      end
      JLD_SPTR: begin
        // indirect or indexed source: follow the pointer
        c_nxt.reg_req.raddr = (d.skind == JLD_K_IDX) ? reg_rdata + d.x
                                                     : reg_rdata;
        c_nxt.st = JLD_SVAL;
      end
      JLD_SVAL: c_nxt = put_val(c_nxt, d, reg_rdata);
      JLD_DPTR: begin
        c_nxt.reg_req.we    = 1'b1;
        c_nxt.reg_req.waddr = (d.dkind == JLD_K_IDX) ? reg_rdata + d.x
                                                     : reg_rdata;
        c_nxt.reg_req.wdata = c_r.val;
        c_nxt.st            = JLD_PAD;
      end
      JLD_JHI: begin
        c_nxt.hi            = reg_rdata;
        c_nxt.reg_req.raddr = {by[1][7:1], 1'b1};
        c_nxt.st            = JLD_JLO;
      end
      JLD_JLO: begin
        c_nxt.pc = {c_r.hi, reg_rdata};
        c_nxt.st = JLD_PAD;
      end
      JLD_BIT1: begin
        c_nxt.val           = reg_rdata;
        c_nxt.reg_req.raddr = by[1][0] ? by[2] : wreg(by[1][7:4]);
        c_nxt.st            = JLD_BIT2;
      end
      JLD_BIT2: begin
        // merge one bit, the rest of the destination as read
        c_nxt.reg_req.we    = 1'b1;
        c_nxt.reg_req.wdata = reg_rdata;
        if (by[1][0]) begin
          c_nxt.reg_req.waddr              = by[2];
          c_nxt.reg_req.wdata[by[1][3:1]]  = c_r.val[0];
        end else begin
          c_nxt.reg_req.waddr    = wreg(by[1][7:4]);
          c_nxt.reg_req.wdata[0] = c_r.val[by[1][3:1]];
        end
        c_nxt.st = JLD_PAD;
      end
      JLD_MHI: begin
        c_nxt.hi            = reg_rdata;
        c_nxt.reg_req.raddr = wreg({pair[3:1], 1'b1});
        c_nxt.st            = JLD_MLO;
      end
      JLD_MLO: begin
        c_nxt.mem_req.prog = ~pair[0];
        c_nxt.mem_req.addr = direct ? {by[3], by[2]}
                                    : {c_r.hi, reg_rdata} + d.xoff;
        if (by[0][4]) begin
          c_nxt.reg_req.raddr = wreg(by[1][7:4]);
        end else begin
          c_nxt.mem_req.rd = 1'b1;
        end
        c_nxt.st = JLD_MEM;
      end
      JLD_MEM: begin
        if (by[0][4]) begin
          c_nxt.mem_req.wr    = 1'b1;
          c_nxt.mem_req.wdata = reg_rdata;
        end else begin
          c_nxt.reg_req.we    = 1'b1;
          c_nxt.reg_req.waddr = wreg(by[1][7:4]);
          c_nxt.reg_req.wdata = mem_rdata;
        end
        c_nxt.st = JLD_PAD;
      end
      JLD_PAD: c_nxt.st = JLD_PAD;
    endcase
    // hold each instruction to its cycle budget, then fetch the next
    if ((c_nxt.st == JLD_PAD) && (c_r.cnt >= d.cyc - 4'd1)) begin
      c_nxt.st        = JLD_FETCH;
      c_nxt.fetch_req = 1'b1;
      c_nxt.cnt       = 4'd0;
      c_nxt.done      = 1'b1;
    end
  end

  // all state in one register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      c_r    <= '0;
      c_r.pc <= `JLD_PC_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign fetch_req  = c_r.fetch_req;
  assign fetch_addr = c_r.pc;
  assign cond_code  = c_r.cond_code;
  assign reg_req    = c_r.reg_req;
  assign mem_req    = c_r.mem_req;
  assign flags_we   = c_r.flags_we;
  assign instr_done = c_r.done;
  assign unsup_op   = c_r.unsup;

endmodule

// ---- test/jld_decoder_monitor.sv ----
/*
  Checker for the jump and load decoder, watching its ports only.
  Assumes one clock, core_clk, and a synchronous active-high rst.
*/
`timescale 1ns/10ps
module jld_decoder_monitor
  import jld_pkg::*;
(
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         fetch_req,
  input wire logic [15:0]  fetch_addr,
  input wire logic [7:0]   fetch_data,
  input wire logic [3:0]   cond_code,
  input wire logic         cond_ok,
  input wire jld_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire jld_mem_req_t mem_req,
  input wire logic [7:0]   mem_rdata,
  input wire logic         flags_we,
  input wire logic         instr_done,
  input wire logic         unsup_op
);
  logic       fr_d_r;
  logic       fr_d2_r;
  logic [7:0] b1_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // second byte kept, the memory selection is judged cycles later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fr_d_r  <= 1'b0;
      fr_d2_r <= 1'b0;
    end else begin
      fr_d_r  <= fetch_req;
      fr_d2_r <= fr_d_r;
      if (fetch_req && fr_d_r && !fr_d2_r) begin
        b1_r <= fetch_data;
      end
    end
  end

  property p_flags_quiet;
    !flags_we;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet)
    else $error("flag write seen");

  property p_reset_quiet;
    $past(rst) |-> !fetch_req && fetch_addr == 16'h0000 && !reg_req.we
      && !mem_req.rd && !mem_req.wr && !instr_done;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs busy right after reset");

  property p_jpcc_timing;
    $rose(fetch_req) && fetch_data[3:0] == 4'hd |->
      fetch_req [*3] ##1 !fetch_req [*5] ##1 $rose(fetch_req);
  endproperty
  a_jpcc_timing: assert property (p_jpcc_timing)
    else $error("conditional jump length or period wrong");

  property p_jpind_timing;
    $rose(fetch_req) && fetch_data == 8'h30 |->
      fetch_req [*2] ##1 !fetch_req [*6] ##1 instr_done;
  endproperty
  a_jpind_timing: assert property (p_jpind_timing)
    else $error("indirect jump length or period wrong");

  property p_jr_timing;
    $rose(fetch_req) && fetch_data[3:0] == 4'hb |->
      fetch_req [*2] ##1 !fetch_req [*4] ##1 $rose(fetch_req);
  endproperty
  a_jr_timing: assert property (p_jr_timing)
    else $error("relative jump length or period wrong");

  property p_short_move;
    $rose(fetch_req) && fetch_data[3:0] inside {4'hc, 4'h8, 4'h9} |->
      fetch_req [*2] ##1 !fetch_req [*2] ##1 instr_done;
  endproperty
  a_short_move: assert property (p_short_move)
    else $error("short move length or period wrong");

  property p_six_cycle;
    $rose(fetch_req) && fetch_data inside {8'he4, 8'he6, 8'h47} |->
      fetch_req [*3] ##1 !fetch_req [*3] ##1 instr_done;
  endproperty
  a_six_cycle: assert property (p_six_cycle)
    else $error("three byte move length or period wrong");

  property p_ind_mem;
    $rose(fetch_req) && fetch_data inside {8'hc3, 8'hd3} |->
      fetch_req [*2] ##1 !fetch_req [*8] ##1 $rose(fetch_req);
  endproperty
  a_ind_mem: assert property (p_ind_mem)
    else $error("indirect memory move length or period wrong");

  property p_long_mem;
    $rose(fetch_req) && fetch_data inside {8'ha7, 8'hb7} |->
      fetch_req [*4] ##1 !fetch_req [*8] ##1 !fetch_req [*2] ##1 instr_done;
  endproperty
  a_long_mem: assert property (p_long_mem)
    else $error("long memory move length or period wrong");

  property p_mem_to_reg;
    mem_req.rd |=> reg_req.we && reg_req.wdata == $past(mem_rdata)
      && reg_req.waddr[7:4] == 4'hc;
  endproperty
  a_mem_to_reg: assert property (p_mem_to_reg)
    else $error("memory byte not written to working register");

  property p_mem_select;
    (mem_req.rd || mem_req.wr) |-> mem_req.prog == !b1_r[0];
  endproperty
  a_mem_select: assert property (p_mem_select)
    else $error("memory space does not follow pair field");

  // an opcode outside our set is skipped but must still be flagged
  property p_unsup_flag;
    $rose(fetch_req) && fetch_data == 8'hff |=> unsup_op;
  endproperty
  a_unsup_flag: assert property (p_unsup_flag)
    else $error("unknown opcode not flagged");

  c_jr_start: cover property ($rose(fetch_req) && fetch_data[3:0] == 4'hb);
  c_jp_ind: cover property ($rose(fetch_req) && fetch_data == 8'h30);
  c_mem_read: cover property (mem_req.rd);
  c_mem_write: cover property (mem_req.wr);
endmodule

bind jld_decoder jld_decoder_monitor jld_decoder_monitor_inst (
  .core_clk (core_clk), .rst (rst), .fetch_req (fetch_req),
  .fetch_addr (fetch_addr), .fetch_data (fetch_data),
  .cond_code (cond_code), .cond_ok (cond_ok), .reg_req (reg_req),
  .reg_rdata (reg_rdata), .mem_req (mem_req), .mem_rdata (mem_rdata),
  .flags_we (flags_we), .instr_done (instr_done), .unsup_op (unsup_op)
);

// ---- test/jld_partner_model.sv ----
/*
  Far side of the decoder: program memory, register file, data memory
  and a stand-in condition evaluator.
  Assumes the bench preloads the arrays by hierarchical reference.
*/
`timescale 1ns/10ps
module jld_partner_model
  import jld_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         fetch_req,
  input  wire logic [15:0]  fetch_addr,
  output logic [7:0]        fetch_data,
  input  wire logic [3:0]   cond_code,
  output logic              cond_ok,
  input  wire jld_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire jld_mem_req_t mem_req,
  output logic [7:0]        mem_rdata
);
  logic [7:0] pmem [0:8191];
  logic [7:0] dmem [0:8191];
  logic [7:0] regs [0:255];
  logic [7:0] noise_r;

  // empty program space reads as an unsupported opcode
  initial begin
    for (int i = 0; i < 8192; i++) begin
      pmem[i] = 8'hff;
      dmem[i] = 8'h00;
    end
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'h00;
    end
    noise_r = 8'h3c;
  end

  // conditions with the top bit set count as true
  assign cond_ok = cond_code[3];
  // idle buses show a changing pattern, never a stale byte
  assign fetch_data = fetch_req ? pmem[fetch_addr[12:0]] : noise_r;
  assign reg_rdata = regs[reg_req.raddr];
  assign mem_rdata = !mem_req.rd ? noise_r :
    mem_req.prog ? pmem[mem_req.addr[12:0]] : dmem[mem_req.addr[12:0]];

  // writes land at the edge ending the strobe cycle
  always @(posedge core_clk) begin
    noise_r <= {noise_r[6:0], ~noise_r[7]};
    if (reg_req.we) begin
      regs[reg_req.waddr] <= reg_req.wdata;
    end
    if (mem_req.wr && mem_req.prog) begin
      pmem[mem_req.addr[12:0]] <= mem_req.wdata;
    end
    if (mem_req.wr && !mem_req.prog) begin
      dmem[mem_req.addr[12:0]] <= mem_req.wdata;
    end
  end
endmodule

// ---- test/jld_decoder_tb_top.sv ----
/*
  Self-checking bench for the jump and load decoder with its partner.
  Assumes programs start at address 0000 after each reset.
*/
`timescale 1ns/10ps
module jld_decoder_tb_top;
  import jld_pkg::*;
  logic         core_clk;
  logic         rst;
  logic         fetch_req;
  logic [15:0]  fetch_addr;
  logic [7:0]   fetch_data;
  logic [3:0]   cond_code;
  logic         cond_ok;
  jld_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  jld_mem_req_t mem_req;
  logic [7:0]   mem_rdata;
  logic         flags_we;
  logic         instr_done;
  logic         unsup_op;
  int           fail_count = 0;
  int           tests_run = 0;
  logic [15:0]  gaps [$];
  logic [15:0]  nxt [$];

  jld_decoder jld_decoder_inst (
    .core_clk (core_clk), .rst (rst), .fetch_req (fetch_req),
    .fetch_addr (fetch_addr), .fetch_data (fetch_data),
    .cond_code (cond_code), .cond_ok (cond_ok), .reg_req (reg_req),
    .reg_rdata (reg_rdata), .mem_req (mem_req), .mem_rdata (mem_rdata),
    .flags_we (flags_we), .instr_done (instr_done), .unsup_op (unsup_op));
  jld_partner_model mdl (
    .core_clk (core_clk), .fetch_req (fetch_req),
    .fetch_addr (fetch_addr), .fetch_data (fetch_data),
    .cond_code (cond_code), .cond_ok (cond_ok), .reg_req (reg_req),
    .reg_rdata (reg_rdata), .mem_req (mem_req), .mem_rdata (mem_rdata));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [7:0] v);
    check({8'h00, mdl.regs[a]}, {8'h00, v});
  endtask

  // reset first so no late write of the last run hits the presets
  task automatic load(input logic [7:0] b [$]);
    @(posedge core_clk);
    rst <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      mdl.pmem[i] = (i < b.size()) ? b[i] : 8'hff;
    end
  endtask

  // records cycles per instruction and the next fetch address
  task automatic run(input int n);
    int t;
    int k;
    gaps.delete();
    nxt.delete();
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t = 0;
    k = 0;
    while (fetch_req !== 1'b1 && t < 10) begin
      @(negedge core_clk);
      t++;
    end
    t = 0;
    while (k < n && t < 100) begin
      @(negedge core_clk);
      t++;
      if (instr_done === 1'b1) begin
        gaps.push_back(16'(t));
        nxt.push_back(fetch_addr);
        t = 0;
        k++;
      end
    end
    check(16'(k), 16'(n));
  endtask

  task automatic t_jump();
    load('{8'h8d, 8'h01, 8'h20});
    run(1);
    check(gaps[0], 16'd8);
    check(nxt[0], 16'h0120);
    check({12'h000, cond_code}, 16'h0008);
    load('{8'h0d, 8'h01, 8'h20});
    run(1);
    check(nxt[0], 16'h0003);
    load('{8'h30, 8'h00});
    mdl.regs[0] = 8'h01;
    mdl.regs[1] = 8'h20;
    run(1);
    check(gaps[0], 16'd8);
    check(nxt[0], 16'h0120);
  endtask

  // both offset extremes, a false condition and a jump onto itself
  task automatic t_rel();
    logic [7:0]  op [4] = '{8'h8b, 8'h8b, 8'h0b, 8'hfb};
    logic [7:0]  off [4] = '{8'h7f, 8'h80, 8'h80, 8'hfe};
    logic [15:0] tgt [4] = '{16'h0081, 16'hff82, 16'h0002, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      load('{op[i], off[i]});
      run(1);
      check(gaps[0], 16'd6);
      check(nxt[0], tgt[i]);
    end
  endtask

  task automatic t_move();
    logic [15:0] g [9] = '{16'd4, 16'd6, 16'd6, 16'd4, 16'd4, 16'd6,
                           16'd6, 16'd6, 16'd4};
    // indirect destination, indirect source and indexed destination too
    load('{8'h3c, 8'h5a, 8'he4, 8'hc3, 8'h40, 8'he6, 8'h41, 8'h99,
           8'h28, 8'h40, 8'h29, 8'h42, 8'hd6, 8'h42, 8'h33,
           8'he5, 8'h42, 8'h44, 8'h97, 8'h34, 8'h10});
    run(9);
    reg_is(8'h5a, 8'h33);
    reg_is(8'h44, 8'h33);
    reg_is(8'h10, 8'h5a);
    for (int i = 0; i < 9; i++) begin
      check(gaps[i], g[i]);
    end
    reg_is(8'hc3, 8'h5a);
    reg_is(8'h40, 8'h5a);
    reg_is(8'h41, 8'h99);
    reg_is(8'hc2, 8'h5a);
    reg_is(8'h42, 8'h5a);
  endtask

  // one load into a working register, one store into a general one
  task automatic t_bit();
    load('{8'h47, 8'h04, 8'h00, 8'h47, 8'h11, 8'h01});
    mdl.regs[8'hc0] = 8'h06;
    mdl.regs[8'h00] = 8'h05;
    mdl.regs[8'hc1] = 8'h06;
    mdl.regs[8'h01] = 8'h05;
    run(3);
    check(gaps[0], 16'd6);
    check(gaps[1], 16'd6);
    reg_is(8'hc0, 8'h07);
    reg_is(8'h00, 8'h05);
    reg_is(8'h01, 8'h04);
    reg_is(8'hc1, 8'h06);
  endtask

  // pair field 0 and 1 in A7 select the direct forms
  task automatic t_mem();
    logic [15:0] g [11] = '{16'd10, 16'd10, 16'd12, 16'd14, 16'd14,
                            16'd14, 16'd10, 16'd12, 16'd14, 16'd14, 16'd4};
    load('{8'hc3, 8'h02, 8'hc3, 8'h13, 8'he7, 8'h52, 8'h01,
           8'ha7, 8'h62, 8'h00, 8'h10, 8'ha7, 8'h71, 8'h04, 8'h11,
           8'ha7, 8'h80, 8'h04, 8'h11, 8'hd3, 8'h43, 8'hf7, 8'h43, 8'h02,
           8'hb7, 8'h41, 8'h05, 8'h11, 8'hb7, 8'h42, 8'h00, 8'h08});
    mdl.regs[8'hc2] = 8'h01;
    mdl.regs[8'hc3] = 8'h04;
    mdl.regs[8'hc4] = 8'h77;
    mdl.pmem[16'h0104] = 8'h1a;
    mdl.pmem[16'h0105] = 8'h6d;
    mdl.pmem[16'h1104] = 8'h88;
    mdl.dmem[16'h0104] = 8'h2a;
    mdl.dmem[16'h1104] = 8'h98;
    run(11);
    for (int i = 0; i < 11; i++) begin
      check(gaps[i], g[i]);
    end
    reg_is(8'hc0, 8'h1a);
    reg_is(8'hc1, 8'h2a);
    reg_is(8'hc5, 8'h6d);
    reg_is(8'hc6, 8'h88);
    reg_is(8'hc7, 8'h98);
    reg_is(8'hc8, 8'h88);
    reg_is(8'hc2, 8'h01);
    reg_is(8'hc3, 8'h04);
    check({8'h00, mdl.dmem[16'h0104]}, 16'h0077);
    check({8'h00, mdl.dmem[16'h0106]}, 16'h0077);
    check({8'h00, mdl.dmem[16'h1105]}, 16'h0077);
    check({8'h00, mdl.pmem[16'h0904]}, 16'h0077);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    repeat (5) @(posedge core_clk);
    t_jump();
    t_rel();
    t_move();
    t_bit();
    t_mem();
    tally_and_finish();
  end
endmodule
